// [inc/hpd_params.svh]
// Constants of the homing and position detect block
`ifndef HPD_PARAMS_SVH
`define HPD_PARAMS_SVH

// Clock period and deceleration time unit, in ns
`define HPD_CLK_NS        100
`define HPD_DECEL_UNIT_NS 100000

// Register word indexes
`define HPD_A_CTRL     4'h0
`define HPD_A_HSPD     4'h1
`define HPD_A_CREEP    4'h2
`define HPD_A_SHIFT    4'h3
`define HPD_A_HOME     4'h4
`define HPD_A_HRANGE   4'h5
`define HPD_A_DECEL    4'h6
`define HPD_A_SOFTP    4'h7
`define HPD_A_SOFTN    4'h8
`define HPD_A_LIMP     4'h9
`define HPD_A_LIMN     4'hA
`define HPD_A_DETPOS   4'hB
`define HPD_A_DETRNG   4'hC
`define HPD_A_OVRW     4'hD
`define HPD_A_STATUS   4'hE
`define HPD_A_CURPOS   4'hF

// Control register fields
`define HPD_F_MODE     2:0
`define HPD_F_FMT      3
`define HPD_F_SDIR     4
`define HPD_F_HDIR     5
`define HPD_F_EDGE     6
`define HPD_F_OTACT    7
`define HPD_F_DETFMT   9:8

// Reset values
`define HPD_R_CTRL     32'h0000_0000
`define HPD_R_HSPD     32'h0000_C350
`define HPD_R_CREEP    32'h0000_1388
`define HPD_R_SHIFT    32'h0000_03E8
`define HPD_R_HOME     32'h0000_0000
`define HPD_R_HRANGE   32'h0000_0000
`define HPD_R_DECEL    32'h0000_03E8
`define HPD_R_SOFTP    32'h0BEB_C200
`define HPD_R_SOFTN    32'h88CA_6C00
`define HPD_R_LIMP     32'h0BEB_C200
`define HPD_R_LIMN     32'h88CA_6C00
`define HPD_R_DETPOS   32'h0000_0000
`define HPD_R_DETRNG   32'h0000_0064
`define HPD_R_OVRW     32'h5028_140A

// Travel bound of normal point-to-point format
`define HPD_PTP_MAX    32'sh0BEB_C200
`define HPD_PTP_MIN    (-32'sh0BEB_C200)

// Control modes and override figure without override
`define HPD_MODE_SOFT_LO 3'h1
`define HPD_MODE_SOFT_HI 3'h6
`define HPD_MODE_PTP     3'h7
`define HPD_OVR_FULL     10'h064

`endif

// [inc/hpd_pkg.sv]
// Types of the homing and position detect block
package hpd_pkg;

    typedef logic signed [31:0] hpd_pos_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FAST  = 3'b001,
        ST_CREEP = 3'b010,
        ST_SHIFT = 3'b011,
        ST_DECEL = 3'b100
    } hpd_state_t;

    typedef enum logic [1:0] {
        DET_POINT = 2'b00,
        DET_ABOVE = 2'b01,
        DET_BELOW = 2'b10
    } hpd_det_t;

endpackage

// [logic/hpd_cmp.sv]
// Point and area position comparator with registered output
`timescale 1ns/1ps
module hpd_cmp
    import hpd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire hpd_pos_t   pos,
    input  wire hpd_pos_t   ref_pos,
    input  wire logic [31:0] range,
    input  wire logic [1:0] mode,
    output logic            hit_q
);
    logic signed [32:0] diff;
    logic        [32:0] mag;
    logic               hit_d;

    // Distance from reference and the selected test
    always_comb begin
        diff = 33'(pos) - 33'(ref_pos);
        mag  = diff[32] ? 33'(-diff) : 33'(diff);
        case (mode)
            DET_POINT: hit_d = (mag <= {1'b0, range});
            DET_ABOVE: hit_d = !diff[32];
            DET_BELOW: hit_d = diff[32] || diff == 0;
            default:   hit_d = 1'b0;
        endcase
    end

    // Evaluated every cycle against the given position
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= hit_d;
        end
    end

    chk_area_above: assert property (@(posedge clk) disable iff (!rst_n)
        mode == DET_ABOVE |=> hit_q == ($past(pos) >= $past(ref_pos)))
        else $error("area above output wrong");
    chk_area_below: assert property (@(posedge clk) disable iff (!rst_n)
        mode == DET_BELOW |=> hit_q == ($past(pos) <= $past(ref_pos)))
        else $error("area below output wrong");

endmodule

// [logic/hpd_top.sv]
// Homing sequencer, overtravel stop and position detection
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "hpd_params.svh"
module hpd_top
    import hpd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        HOMING_START_INPUT,
    input  wire logic        HOME_REFERENCE_SWITCH,
    input  wire logic        ENC_INDEX,
    input  wire logic        POSITIVE_TRAVEL_LIMIT_INPUT,
    input  wire logic        NEGATIVE_TRAVEL_LIMIT_INPUT,
    input  wire logic        POSITION_START,
    input  wire logic        OVERRIDE_ENABLE,
    input  wire logic [3:0]  OVERRIDE_BITS,
    input  wire logic [31:0] POS_FB,
    output logic      [31:0] SPEED_CMD,
    output logic             DIR_REV,
    output logic             HOMING_DONE,
    output logic             FORCE_STOP,
    output logic             LIMITER_POS,
    output logic             LIMITER_NEG,
    output logic             EXTENDED_OUTPUT_TERMINAL,
    output logic      [9:0]  OVERRIDE_PCT,
    output logic      [31:0] CUR_POS
);
    localparam int TICK_CYC = `HPD_DECEL_UNIT_NS / `HPD_CLK_NS;

    generate
        if (TICK_CYC < 1 || TICK_CYC > 1023) begin : g_bad
            $error("decel tick count does not fit its counter");
        end
    endgenerate

    logic        rst_s1_q;
    logic        rst_n;
    logic [31:0] ctrl_q;
    logic [31:0] hspd_q;
    logic [31:0] creep_q;
    logic [31:0] shift_q;
    hpd_pos_t    home_q;
    logic [31:0] hrange_q;
    logic [31:0] decel_q;
    hpd_pos_t    softp_q;
    hpd_pos_t    softn_q;
    hpd_pos_t    limp_q;
    hpd_pos_t    limn_q;
    hpd_pos_t    detpos_q;
    logic [31:0] detrng_q;
    logic [31:0] ovrw_q;
    hpd_state_t  state_q;
    hpd_pos_t    target_q;
    hpd_pos_t    offset_q;
    hpd_pos_t    cur_pos;
    hpd_pos_t    to_go;
    logic        homed_q;
    logic        start_prev_q;
    logic        sw_prev_q;
    logic [9:0]  tick_q;
    logic [31:0] decel_cnt_q;
    logic        start_edge;
    logic        ref_edge;
    logic        ot_hit;
    logic        reached;
    logic        decel_done;
    logic        zero_preset;
    logic        soft_en;
    logic        ptp_mode;
    logic        home_near;
    logic [9:0]  ovr_sum;

    // Reset release through two flops
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Register writes
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= `HPD_R_CTRL;
            hspd_q   <= `HPD_R_HSPD;
            creep_q  <= `HPD_R_CREEP;
            shift_q  <= `HPD_R_SHIFT;
            home_q   <= `HPD_R_HOME;
            hrange_q <= `HPD_R_HRANGE;
            decel_q  <= `HPD_R_DECEL;
            softp_q  <= `HPD_R_SOFTP;
            softn_q  <= `HPD_R_SOFTN;
            limp_q   <= `HPD_R_LIMP;
            limn_q   <= `HPD_R_LIMN;
            detpos_q <= `HPD_R_DETPOS;
            detrng_q <= `HPD_R_DETRNG;
            ovrw_q   <= `HPD_R_OVRW;
        end else if (WR) begin
            case (ADDR)
                `HPD_A_CTRL:   ctrl_q   <= WDATA;
                `HPD_A_HSPD:   hspd_q   <= WDATA;
                `HPD_A_CREEP:  creep_q  <= WDATA;
                `HPD_A_SHIFT:  shift_q  <= WDATA;
                `HPD_A_HOME:   home_q   <= WDATA;
                `HPD_A_HRANGE: hrange_q <= WDATA;
                `HPD_A_DECEL:  decel_q  <= WDATA;
                `HPD_A_SOFTP:  softp_q  <= WDATA;
                `HPD_A_SOFTN:  softn_q  <= WDATA;
                `HPD_A_LIMP:   limp_q   <= WDATA;
                `HPD_A_LIMN:   limn_q   <= WDATA;
                `HPD_A_DETPOS: detpos_q <= WDATA;
                `HPD_A_DETRNG: detrng_q <= WDATA;
                `HPD_A_OVRW:   ovrw_q   <= WDATA;
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe; zero otherwise
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            case (ADDR)
                `HPD_A_CTRL:   RDATA <= ctrl_q;
                `HPD_A_HSPD:   RDATA <= hspd_q;
                `HPD_A_CREEP:  RDATA <= creep_q;
                `HPD_A_SHIFT:  RDATA <= shift_q;
                `HPD_A_HOME:   RDATA <= home_q;
                `HPD_A_HRANGE: RDATA <= hrange_q;
                `HPD_A_DECEL:  RDATA <= decel_q;
                `HPD_A_SOFTP:  RDATA <= softp_q;
                `HPD_A_SOFTN:  RDATA <= softn_q;
                `HPD_A_LIMP:   RDATA <= limp_q;
                `HPD_A_LIMN:   RDATA <= limn_q;
                `HPD_A_DETPOS: RDATA <= detpos_q;
                `HPD_A_DETRNG: RDATA <= detrng_q;
                `HPD_A_OVRW:   RDATA <= ovrw_q;
                `HPD_A_STATUS: RDATA <= {24'h00_0000, state_q,
                    EXTENDED_OUTPUT_TERMINAL, LIMITER_NEG,
                    LIMITER_POS, FORCE_STOP, HOMING_DONE};
                `HPD_A_CURPOS: RDATA <= CUR_POS;
                default:       RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

    // Mode decode of the shared format bit
    always_comb begin
        ptp_mode    = ctrl_q[`HPD_F_MODE] == `HPD_MODE_PTP;
        soft_en     = ctrl_q[`HPD_F_FMT] && !ptp_mode
            && ctrl_q[`HPD_F_MODE] >= `HPD_MODE_SOFT_LO
            && ctrl_q[`HPD_F_MODE] <= `HPD_MODE_SOFT_HI;
        zero_preset = ctrl_q[`HPD_F_FMT] && ptp_mode;
    end

    // Input edges and homing conditions
    always_comb begin
        start_edge = HOMING_START_INPUT && !start_prev_q;
        ref_edge   = ctrl_q[`HPD_F_EDGE]
            ? (!HOME_REFERENCE_SWITCH && sw_prev_q)
            : (HOME_REFERENCE_SWITCH && !sw_prev_q);
        ot_hit     = !zero_preset
            && ((POSITIVE_TRAVEL_LIMIT_INPUT && !DIR_REV)
            || (NEGATIVE_TRAVEL_LIMIT_INPUT && DIR_REV));
        to_go      = POS_FB - target_q;
        reached    = DIR_REV ? (to_go[31] || to_go == 0)
                             : !to_go[31];
        decel_done = decel_cnt_q >= decel_q;
        cur_pos    = POS_FB - offset_q;
    end

    // Previous input levels
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            start_prev_q <= 1'b0;
            sw_prev_q    <= 1'b0;
        end else begin
            start_prev_q <= HOMING_START_INPUT;
            sw_prev_q    <= HOME_REFERENCE_SWITCH;
        end
    end

    // Deceleration timer in 0.1 ms ticks
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tick_q      <= 10'h000;
            decel_cnt_q <= 32'h0000_0000;
        end else if (state_q != ST_DECEL) begin
            tick_q      <= 10'h000;
            decel_cnt_q <= 32'h0000_0000;
        end else if (tick_q == 10'(TICK_CYC - 1)) begin
            tick_q      <= 10'h000;
            decel_cnt_q <= decel_cnt_q + 32'h0000_0001;
        end else begin
            tick_q      <= tick_q + 10'h001;
        end
    end

    // Homing sequencer
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            SPEED_CMD <= 32'h0000_0000;
            DIR_REV   <= 1'b0;
            target_q  <= 32'sh0000_0000;
            homed_q   <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_edge) begin
                        state_q   <= ST_FAST;
                        SPEED_CMD <= hspd_q;
                        DIR_REV   <= ctrl_q[`HPD_F_SDIR];
                        homed_q   <= 1'b0;
                    end
                end
                ST_FAST: begin
                    if (ot_hit) begin
                        state_q   <= ST_DECEL;
                    end else if (ref_edge) begin
                        state_q   <= ST_CREEP;
                        SPEED_CMD <= creep_q;
                        DIR_REV   <= ctrl_q[`HPD_F_HDIR];
                    end
                end
                ST_CREEP: begin
                    if (ot_hit) begin
                        state_q   <= ST_DECEL;
                    end else if (ENC_INDEX) begin
                        state_q   <= ST_SHIFT;
                        target_q  <= DIR_REV ? POS_FB - shift_q
                                             : POS_FB + shift_q;
                    end
                end
                ST_SHIFT: begin
                    if (reached) begin
                        state_q   <= ST_IDLE;
                        SPEED_CMD <= 32'h0000_0000;
                        homed_q   <= 1'b1;
                    end
                end
                ST_DECEL: begin
                    if (decel_done && ctrl_q[`HPD_F_OTACT]) begin
                        state_q   <= ST_IDLE;
                        SPEED_CMD <= 32'h0000_0000;
                    end else if (decel_done) begin
                        state_q   <= ST_FAST;
                        SPEED_CMD <= hspd_q;
                        DIR_REV   <= !DIR_REV;
                    end
                end
                default: begin
                    state_q   <= ST_IDLE;
                    SPEED_CMD <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Position origin: home at the stop point, zero preset at start
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            offset_q <= 32'sh0000_0000;
        end else if (state_q == ST_SHIFT && reached) begin
            offset_q <= POS_FB - home_q;
        end else if (POSITION_START && zero_preset) begin
            offset_q <= POS_FB;
        end
    end

    // Home distance check and area or point output
    hpd_cmp u_home_cmp (
        .clk     (CLK),
        .rst_n   (rst_n),
        .pos     (cur_pos),
        .ref_pos (home_q),
        .range   (hrange_q),
        .mode    (DET_POINT),
        .hit_q   (home_near)
    );

    hpd_cmp u_det_cmp (
        .clk     (CLK),
        .rst_n   (rst_n),
        .pos     (cur_pos),
        .ref_pos (detpos_q),
        .range   (detrng_q),
        .mode    (ctrl_q[`HPD_F_DETFMT]),
        .hit_q   (EXTENDED_OUTPUT_TERMINAL)
    );

    // Homing complete indication
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            HOMING_DONE <= 1'b0;
        end else begin
            HOMING_DONE <= homed_q && state_q == ST_IDLE
                && (hrange_q == 32'h0000_0000 || home_near);
        end
    end

    // Overtravel stop, limiter flags and current position
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            FORCE_STOP  <= 1'b0;
            LIMITER_POS <= 1'b0;
            LIMITER_NEG <= 1'b0;
            CUR_POS     <= 32'sh0000_0000;
        end else begin
            FORCE_STOP  <= !zero_preset && (
                (soft_en && (cur_pos > softp_q
                    || cur_pos < softn_q))
                || (ptp_mode && (cur_pos > `HPD_PTP_MAX
                    || cur_pos < `HPD_PTP_MIN))
                || POSITIVE_TRAVEL_LIMIT_INPUT
                || NEGATIVE_TRAVEL_LIMIT_INPUT);
            LIMITER_POS <= cur_pos >= limp_q;
            LIMITER_NEG <= cur_pos <= limn_q;
            CUR_POS     <= cur_pos;
        end
    end

    // Override: sum of weights of the active bits
    always_comb begin
        ovr_sum = 10'h000;
        for (int i = 0; i < 4; i++) begin
            if (OVERRIDE_BITS[i]) begin
                ovr_sum = ovr_sum + {2'b00, ovrw_q[i*8 +: 8]};
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            OVERRIDE_PCT <= `HPD_OVR_FULL;
        end else begin
            OVERRIDE_PCT <= OVERRIDE_ENABLE ? ovr_sum
                                            : `HPD_OVR_FULL;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    sequence s_idle_start;
        state_q == ST_IDLE && start_edge;
    endsequence
    sequence s_fast_speed;
        state_q == ST_FAST && SPEED_CMD == $past(hspd_q);
    endsequence

    chk_start_fast: assert property (
        s_idle_start |=> s_fast_speed)
        else $error("homing start did not launch fast move");
    chk_ref_creep: assert property (
        state_q == ST_FAST && ref_edge && !ot_hit |=>
        SPEED_CMD == $past(creep_q)
        && DIR_REV == $past(ctrl_q[`HPD_F_HDIR]))
        else $error("reference switch did not give creep");
    chk_shift_home: assert property (
        state_q == ST_SHIFT && reached |=> state_q == ST_IDLE
        && SPEED_CMD == 0
        && offset_q == $past(POS_FB) - $past(home_q))
        else $error("shift end did not set home");
    chk_ot_action: assert property (
        state_q == ST_DECEL && decel_done |=>
        (ctrl_q[`HPD_F_OTACT] ? state_q == ST_IDLE
            : DIR_REV != $past(DIR_REV)))
        else $error("limit action wrong");
    chk_decel_hold: assert property (
        state_q == ST_DECEL && !decel_done |=> state_q == ST_DECEL)
        else $error("deceleration left early");
    chk_soft_stop: assert property (
        soft_en && cur_pos > softp_q |=> FORCE_STOP)
        else $error("soft limit not stopping");
    chk_preset_zero: assert property (
        POSITION_START && zero_preset && state_q != ST_SHIFT
        |=> offset_q == $past(POS_FB))
        else $error("zero preset not applied");
    chk_preset_free: assert property (
        zero_preset && $stable(zero_preset) |=> !FORCE_STOP)
        else $error("overtravel active in zero preset");
    chk_ovr_off: assert property (
        !OVERRIDE_ENABLE |=> OVERRIDE_PCT == `HPD_OVR_FULL)
        else $error("override applied while disabled");
    chk_done_hold: assert property (
        HOMING_DONE && hrange_q == 0 && state_q == ST_IDLE
        && !start_edge |=> HOMING_DONE)
        else $error("homing complete dropped");

endmodule

// [bench/hpd_motor_model.sv]
// Motor, encoder and switch model on the far side of the homing block
`timescale 1ns/1ps
module hpd_motor_model
    import hpd_pkg::*;
#(
    parameter int PLIM = 3000
)(
    input  wire logic        clk,
    input  wire logic [31:0] speed,
    input  wire logic        dir_rev,
    input  wire logic        set_en,
    input  wire hpd_pos_t    set_val,
    output hpd_pos_t         pos,
    output logic             ref_sw,
    output logic             index,
    output logic             lim_p,
    output logic             lim_n
);
    // Shaft moves one unit a cycle, one cycle behind the command
    always_ff @(posedge clk) begin
        if (set_en) begin
            pos <= set_val;
        end else if (speed != 32'h0) begin
            pos <= dir_rev ? pos - 1 : pos + 1;
        end
    end
    // Switch window, index mark every 64 units, limits at and beyond +/-PLIM
    assign ref_sw = pos >= 50 && pos <= 59;
    assign index  = pos[5:0] == 6'h00 && speed != 32'h0;
    assign lim_p  = pos >= PLIM;
    assign lim_n  = pos <= -PLIM;
endmodule

// [bench/homing_and_position_detect_tb.sv]
// Self-checking bench of the homing and position detect block
`timescale 1ns/1ps
`include "hpd_params.svh"
module homing_and_position_detect_tb
    import hpd_pkg::*;
;
    logic        clk, rstn, wr, rd, hst, pst, oen, sen;
    logic        dir, done, fst, lpo, lne, ext, rsw, idx, lp, ln;
    logic [3:0]  addr, obits;
    logic [9:0]  ovr;
    logic [31:0] wdata, rdata, speed, cur, d;
    hpd_pos_t    pos, sval;
    int          error_cnt, n_compared, k;
    logic [31:0] rv [14] = '{`HPD_R_CTRL, `HPD_R_HSPD, `HPD_R_CREEP,
        `HPD_R_SHIFT, `HPD_R_HOME, `HPD_R_HRANGE, `HPD_R_DECEL,
        `HPD_R_SOFTP, `HPD_R_SOFTN, `HPD_R_LIMP, `HPD_R_LIMN,
        `HPD_R_DETPOS, `HPD_R_DETRNG, `HPD_R_OVRW};
    int          dp [5] = '{-101, -100, 0, 100, 101};
    logic [31:0] oc [10] = '{32'h9, 32'h9, 32'hE, 32'h1, 32'h7, 32'h7,
        32'hF, 32'h1, 32'h1, 32'hF};
    int          op [10] = '{201, 0, -201, 201, 200000001, 201, 300000000,
        300000000, -300001000, -300001000};
    logic        oe [10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
        1'b1, 1'b0};

    // Clock at 10 MHz
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    hpd_top dut_u (
        .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .HOMING_START_INPUT(hst),
        .HOME_REFERENCE_SWITCH(rsw), .ENC_INDEX(idx),
        .POSITIVE_TRAVEL_LIMIT_INPUT(lp),
        .NEGATIVE_TRAVEL_LIMIT_INPUT(ln), .POSITION_START(pst),
        .OVERRIDE_ENABLE(oen), .OVERRIDE_BITS(obits), .POS_FB(pos),
        .SPEED_CMD(speed), .DIR_REV(dir), .HOMING_DONE(done),
        .FORCE_STOP(fst), .LIMITER_POS(lpo), .LIMITER_NEG(lne),
        .EXTENDED_OUTPUT_TERMINAL(ext), .OVERRIDE_PCT(ovr), .CUR_POS(cur)
    );
    hpd_motor_model #(.PLIM(300000000)) mdl_u (
        .clk(clk), .speed(speed), .dir_rev(dir), .set_en(sen),
        .set_val(sval), .pos(pos), .ref_sw(rsw), .index(idx), .lim_p(lp),
        .lim_n(ln)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask
    // Moves the shaft by hand, then lets the registered outputs settle
    task automatic put(input hpd_pos_t p);
        @(posedge clk);
        sval <= p;
        sen  <= 1'b1;
        @(posedge clk);
        sen  <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic go();
        @(posedge clk);
        hst <= 1'b1;
        repeat (2) @(posedge clk);
        hst <= 1'b0;
        #1;
    endtask
    task automatic pstart();
        @(posedge clk);
        pst <= 1'b1;
        @(posedge clk);
        pst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Homing from zero; creep begins near lo, h is home, t the stop point
    task automatic home(input logic [31:0] c, input int lo, input int h,
        input int t);
        reg_wr(`HPD_A_CTRL, c);
        reg_wr(`HPD_A_HOME, h);
        put(0);
        go();
        check(speed, `HPD_R_HSPD);
        for (k = 0; k < 200 && speed !== `HPD_R_CREEP; k++) @(posedge clk) #1;
        check(pos >= lo && pos <= lo + 5, 1'b1);
        check(dir, c[5]);
        for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge clk) #1;
        check(speed, 32'h0);
        check(pos - cur + h - t <= 1, 1'b1);
        repeat (5) @(posedge clk);
        #1 check(done, 1'b1);
    endtask
    // Homing that runs into the limit ahead; s selects a reverse start
    task automatic ot_run(input logic act, input logic s);
        reg_wr(`HPD_A_CTRL, {24'h00_0000, act, 2'b00, s, 4'h0});
        put(s ? -299999990 : 299999990);
        go();
        check(dir, s);
        for (k = 0; k < 40 && (s ? ln : lp) !== 1'b1; k++) @(posedge clk) #1;
        repeat (990) @(posedge clk);
        #1 check(speed, `HPD_R_HSPD);
        for (k = 0; k < 40 && speed === `HPD_R_HSPD && dir === s; k++)
            @(posedge clk) #1;
        check(speed, act ? 32'h0 : `HPD_R_HSPD);
        check(dir, s ^ !act);
        check(done, 1'b0);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rstn  = 1'b0;
        wr    = 1'b0;
        rd    = 1'b0;
        hst   = 1'b0;
        pst   = 1'b0;
        oen   = 1'b0;
        obits = 4'h0;
        addr  = 4'h0;
        wdata = 32'h0;
        sen   = 1'b1;
        sval  = 500;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        sen <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            reg_rd(i[3:0], d);
            check(d, rv[i]);
        end
        $display("register defaults finished");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            oen   <= 1'b1;
            obits <= i[3:0];
            repeat (2) @(posedge clk);
            #1 check(ovr, 10 * i[0] + 20 * i[1] + 40 * i[2] + 80 * i[3]);
        end
        @(posedge clk);
        oen <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(ovr, `HPD_OVR_FULL);
        $display("override finished");
        reg_wr(`HPD_A_SHIFT, 100);
        reg_wr(`HPD_A_DECEL, 1);
        home(32'h0, 50, 0, 164);
        home(32'h40, 60, 7, 164);
        home(32'h60, 60, 7, -100);
        $display("homing finished");
        reg_wr(`HPD_A_CTRL, 32'hF);
        put(1000);
        pstart();
        check(cur, 32'h0);
        reg_wr(`HPD_A_CTRL, 32'h7);
        put(1300);
        pstart();
        check(cur, 32'h12C);
        $display("zero preset finished");
        reg_wr(`HPD_A_LIMP, 50);
        reg_wr(`HPD_A_LIMN, -50);
        for (int m = 0; m < 3; m++) begin
            reg_wr(`HPD_A_CTRL, {m[1:0], 8'h01});
            for (int j = 0; j < 5; j++) begin
                put(1000 + dp[j]);
                check(ext, m == 0 ? dp[j] <= 100 && dp[j] >= -100 :
                    m == 1 ? dp[j] >= 0 : dp[j] <= 0);
                check(lpo, dp[j] >= 50);
                check(lne, dp[j] <= -50);
            end
        end
        check(done, 1'b1);
        $display("detection finished");
        reg_wr(`HPD_A_SOFTP, 200);
        reg_wr(`HPD_A_SOFTN, -200);
        for (int j = 0; j < 10; j++) begin
            reg_wr(`HPD_A_CTRL, oc[j]);
            put(1000 + op[j]);
            check(fst, oe[j]);
        end
        $display("overtravel finished");
        ot_run(1'b1, 1'b0);
        ot_run(1'b0, 1'b0);
        ot_run(1'b1, 1'b1);
        ot_run(1'b0, 1'b1);
        $display("homing limit finished");
        complete_run();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end
endmodule
